// file: rtl/dsb_consts.vh
// constants for the dac serial/byte host controller
`ifndef DSB_CONSTS_VH
`define DSB_CONSTS_VH

// ---------------------------------------------------------------
// clock and time conversion
// ---------------------------------------------------------------
`define DSB_CLK_MHZ 200
// least time in ns to whole clock cycles, rounded up
`define DSB_CYC(ns) ((((ns) * `DSB_CLK_MHZ) + 999) / 1000)

// ---------------------------------------------------------------
// pin timing in ns
// ---------------------------------------------------------------
`define DSB_T_STROBE_LOW_NS 50
`define DSB_T_PROP_NS 100
`define DSB_T_LOAD_WIDTH_NS 50
`define DSB_T_LOAD_HOLD_NS 100
`define DSB_T_CLR_WIDTH_NS 110
`define DSB_T_CLR_SETUP_NS 110
`define DSB_T_CLR_HOLD_NS 10

// ---------------------------------------------------------------
// register map, byte addresses
// ---------------------------------------------------------------
`define DSB_ADDR_W 4
`define DSB_REG_CTRL 4'h0
`define DSB_REG_DATA 4'h4
`define DSB_REG_CMD 4'h8
`define DSB_REG_STAT 4'hC

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DSB_CTRL_BYTE_MODE 0
`define DSB_CTRL_MSB_FIRST 1
`define DSB_CTRL_BIPOLAR 2
`define DSB_CTRL_AUTO_LOAD 3
`define DSB_CMD_LOAD 0
`define DSB_CMD_CLEAR 1
`define DSB_STAT_BUSY 0
`define DSB_STAT_EMPTY 1
`define DSB_STAT_FULL 2
`define DSB_STAT_OVF 3
`define DSB_STAT_LOAD_PEND 4
`define DSB_STAT_CLR_PEND 5

// ---------------------------------------------------------------
// reset value and sizes
// ---------------------------------------------------------------
`define DSB_CTRL_RESET 4'hA
`define DSB_WORD_W 16
`define DSB_FIFO_DEPTH 16

`endif

// file: rtl/dsb_host.v
// host-side controller driving a 16-bit serial/byte dac through its pins
//
// Contract
// [R1] serial_select_n low selects serial mode; bus bit 0 carries serial data.
// [R2] in serial mode bus bit 1 tells the device the bit order.
// [R3] serial mode ignores upper enable; lower enable only picks clear target.
// [R4] clear goes to unipolar zero with lower enable low, bipolar when high.
// [R5] each rising edge of the select strobe shifts one serial bit in.
// [R6] raising output_latch_load copies the first rank latch into the dac latch.
// [R7] clear resets only the dac latch, first rank latch is kept.
// [R8] after clear host may reload old data or write new data first.
// [R9] first rank latch is a 16-bit shift register feeding serial_data_out.
// [R10] each chained device gets its own load unless all update together.
// [R11] serial_select_n high selects byte mode with eight parallel bus lines.
// [R12] byte enables steer bus into upper or lower half, any order.
// [R13] in byte mode host sets lower enable for clear target before clearing.
// [R14] select strobe is edge acting; byte enables and load are level acting.
// [R15] clear acts asynchronously without waiting for any strobe edge.
// [R16] bit order select high means msb first, low means lsb first.
// [R17] serial_data_out shows final shift stage, updated after each rising edge.
`include "dsb_consts.vh"

// ---------------------------------------------------------------
// word fifo between the register port and the pin sequencer
// ---------------------------------------------------------------
module dsb_fifo #(
  parameter WIDTH = `DSB_WORD_W,
  parameter DEPTH = `DSB_FIFO_DEPTH,
  parameter AW = 4
) (
  input wire clk, // system clock
  input wire rst, // async reset, high
  input wire ce, // clock enable
  input wire in_valid, // push request
  output wire in_ready, // room for a word
  input wire [WIDTH-1:0] in_data, // pushed word
  output wire out_valid, // word available
  input wire out_ready, // pop request
  output wire [WIDTH-1:0] out_data // head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire do_push;
  wire do_pop;

  // full and empty follow the true count, not the pointers alone
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_ff];
  assign do_push = ce & in_valid & in_ready;
  assign do_pop = ce & out_valid & out_ready;

  // storage has no reset, only the pointers and count need one
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointer and occupancy bookkeeping
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop & ~do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// ---------------------------------------------------------------
// top: register port, fifo and pin sequencer
// ---------------------------------------------------------------
module dsb_host #(
  parameter WORD_W = `DSB_WORD_W,
  parameter FIFO_DEPTH = `DSB_FIFO_DEPTH
) (
  input wire clk, // 200 MHz system clock
  input wire rst, // async reset, high
  input wire ce, // clock enable, freezes all state when low
  input wire [`DSB_ADDR_W-1:0] addr, // register byte address
  input wire [31:0] wdata, // write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [31:0] rdata_ff, // read data, cycle after rd
  output reg serial_select_n_ff, // mode pin, low is serial
  output reg [7:0] byte_bus_ff, // parallel data, bit 0 serial in
  output reg upper_byte_enable_n_ff, // upper half latch enable
  output reg lower_byte_enable_n_ff, // lower half enable, clear target
  output reg select_strobe_n_ff, // edge strobe, rising edge shifts
  output reg output_latch_load_ff, // dac latch load, level
  output reg zero_output_strobe_n_ff, // clear strobe
  input wire serial_data_out // chain output of the device
);
  // pin time in ns to an 8-bit cycle count; counts stay far below 256
  function [7:0] cyc8;
    input integer ns;
    integer c;
    begin
      c = `DSB_CYC(ns);
      cyc8 = c[7:0];
    end
  endfunction

  localparam [7:0] LOW_CYC = cyc8(`DSB_T_STROBE_LOW_NS);
  localparam [7:0] HIGH_CYC = cyc8(`DSB_T_PROP_NS);
  localparam [7:0] LOAD_CYC = cyc8(`DSB_T_LOAD_WIDTH_NS);
  localparam [7:0] LGAP_CYC = cyc8(`DSB_T_LOAD_HOLD_NS);
  localparam [7:0] CLR_CYC = cyc8(`DSB_T_CLR_WIDTH_NS);
  localparam [7:0] CSET_CYC = cyc8(`DSB_T_CLR_SETUP_NS);
  localparam [7:0] CHOLD_CYC = cyc8(`DSB_T_CLR_HOLD_NS);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_SLOW = 4'h1;
  localparam [3:0] S_SHIGH = 4'h2;
  localparam [3:0] S_BLOW = 4'h3;
  localparam [3:0] S_BHIGH = 4'h4;
  localparam [3:0] S_LGAP = 4'h5;
  localparam [3:0] S_LOAD = 4'h6;
  localparam [3:0] S_CSET = 4'h7;
  localparam [3:0] S_CLR = 4'h8;
  localparam [3:0] S_CHOLD = 4'h9;

  // address match, shared by the read and write decode
  function hit;
    input [`DSB_ADDR_W-1:0] a;
    input [`DSB_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  reg [3:0] ctrl_ff;
  reg ovf_ff;
  reg load_pend_ff;
  reg clr_pend_ff;
  reg [3:0] state_ff;
  reg [7:0] tmr_ff;
  reg [3:0] bit_cnt_ff;
  reg [WORD_W-1:0] sh_ff;
  reg [WORD_W-1:0] rx_ff;
  reg [WORD_W-1:0] rx_word_ff;
  reg upper_done_ff;
  reg serial_data_out_meta_ff;
  reg serial_data_out_sync_ff;
  reg take_load;
  reg take_clr;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WORD_W-1:0] fifo_out_data;
  wire fifo_pop;
  wire push;
  wire byte_mode;
  wire msb_first;
  wire idle;

  assign byte_mode = ctrl_ff[`DSB_CTRL_BYTE_MODE];
  assign msb_first = ctrl_ff[`DSB_CTRL_MSB_FIRST];
  assign idle = (state_ff == S_IDLE);
  assign push = wr & hit(addr, `DSB_REG_DATA);
  // a word is only taken when nothing of higher priority waits
  assign fifo_pop = idle & fifo_out_valid & ~clr_pend_ff & ~load_pend_ff;

  dsb_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(wdata[WORD_W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // chain return pin crosses into clk through two flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_data_out_meta_ff <= 1'b0;
      serial_data_out_sync_ff <= 1'b0;
    end else if (ce) begin
      serial_data_out_meta_ff <= serial_data_out;
      serial_data_out_sync_ff <= serial_data_out_meta_ff;
    end
  end

  // sequencer accepts pending commands only while idle
  always @* begin
    take_clr = idle & clr_pend_ff;
    take_load = idle & ~clr_pend_ff & load_pend_ff;
  end

  // register file; a pending flag set by software while taken stays set
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `DSB_CTRL_RESET;
      ovf_ff <= 1'b0;
      load_pend_ff <= 1'b0;
      clr_pend_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else if (ce) begin
      if (wr & hit(addr, `DSB_REG_CTRL) & idle) begin
        ctrl_ff <= wdata[3:0];
      end
      if (push & ~fifo_in_ready) begin
        ovf_ff <= 1'b1;
      end else if (wr & hit(addr, `DSB_REG_STAT) & wdata[`DSB_STAT_OVF]) begin
        ovf_ff <= 1'b0;
      end
      if (wr & hit(addr, `DSB_REG_CMD) & wdata[`DSB_CMD_LOAD]) begin
        load_pend_ff <= 1'b1; // R8 R10
      end else if (take_load) begin
        load_pend_ff <= 1'b0;
      end
      if (wr & hit(addr, `DSB_REG_CMD) & wdata[`DSB_CMD_CLEAR]) begin
        clr_pend_ff <= 1'b1;
      end else if (take_clr) begin
        clr_pend_ff <= 1'b0;
      end
      rdata_ff <= 32'h00000000;
      if (rd) begin
        if (hit(addr, `DSB_REG_CTRL)) begin
          rdata_ff <= {28'h0000000, ctrl_ff};
        end else if (hit(addr, `DSB_REG_DATA)) begin
          rdata_ff <= {16'h0000, rx_word_ff};
        end else if (hit(addr, `DSB_REG_STAT)) begin
          rdata_ff <= {26'h0000000, clr_pend_ff, load_pend_ff, ovf_ff,
                       ~fifo_in_ready, ~fifo_out_valid, ~idle};
        end
      end
    end
  end

  // pin sequencer; every pin is a flop so no glitch reaches the device
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      tmr_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      sh_ff <= 16'h0000;
      rx_ff <= 16'h0000;
      rx_word_ff <= 16'h0000;
      upper_done_ff <= 1'b0;
      serial_select_n_ff <= 1'b1;
      byte_bus_ff <= 8'h00;
      upper_byte_enable_n_ff <= 1'b1;
      lower_byte_enable_n_ff <= 1'b1;
      select_strobe_n_ff <= 1'b1;
      output_latch_load_ff <= 1'b0;
      zero_output_strobe_n_ff <= 1'b1;
    end else if (ce) begin
      if (tmr_ff != 8'h00) begin
        tmr_ff <= tmr_ff - 8'h01;
      end
      case (state_ff)
        S_IDLE: begin
          serial_select_n_ff <= byte_mode; // R1 R11
          if (~byte_mode) begin
            // strapped to the clear target while serial; upper enable unused
            lower_byte_enable_n_ff <= ctrl_ff[`DSB_CTRL_BIPOLAR]; // R3
            upper_byte_enable_n_ff <= 1'b1; // R3
          end else begin
            lower_byte_enable_n_ff <= 1'b1;
            upper_byte_enable_n_ff <= 1'b1;
          end
          if (take_clr) begin
            // clear target set up on lower enable before the strobe
            lower_byte_enable_n_ff <= ctrl_ff[`DSB_CTRL_BIPOLAR]; // R4 R13
            tmr_ff <= CSET_CYC - 8'h01;
            state_ff <= S_CSET;
          end else if (take_load) begin
            tmr_ff <= LOAD_CYC - 8'h01;
            output_latch_load_ff <= 1'b1; // R6 R8
            state_ff <= S_LOAD;
          end else if (fifo_pop & ~byte_mode) begin
            sh_ff <= fifo_out_data;
            bit_cnt_ff <= 4'h0;
            byte_bus_ff <= {6'h00, msb_first,
                            msb_first ? fifo_out_data[15] : fifo_out_data[0]}; // R1 R2 R16
            select_strobe_n_ff <= 1'b0;
            tmr_ff <= LOW_CYC - 8'h01;
            state_ff <= S_SLOW;
          end else if (fifo_pop) begin
            // lower half first; the device takes either order
            sh_ff <= fifo_out_data;
            upper_done_ff <= 1'b0;
            byte_bus_ff <= fifo_out_data[7:0];
            lower_byte_enable_n_ff <= 1'b0; // R12 R14
            select_strobe_n_ff <= 1'b0;
            tmr_ff <= LOW_CYC - 8'h01;
            state_ff <= S_BLOW;
          end
        end
        S_SLOW: begin
          if (tmr_ff == 8'h00) begin
            // device output still shows the stage about to leave
            rx_ff <= {rx_ff[14:0], serial_data_out_sync_ff}; // R9 R17
            select_strobe_n_ff <= 1'b1; // R5 R14
            tmr_ff <= HIGH_CYC - 8'h01;
            state_ff <= S_SHIGH;
          end
        end
        S_SHIGH: begin
          // high phase also covers the chain output settling time
          if (tmr_ff == 8'h00) begin
            if (bit_cnt_ff == 4'hF) begin
              rx_word_ff <= rx_ff;
              tmr_ff <= LGAP_CYC - 8'h01;
              state_ff <= ctrl_ff[`DSB_CTRL_AUTO_LOAD] ? S_LGAP : S_IDLE;
            end else begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              sh_ff <= msb_first ? {sh_ff[14:0], 1'b0} : {1'b0, sh_ff[15:1]};
              byte_bus_ff[0] <= msb_first ? sh_ff[14] : sh_ff[1]; // R1 R16
              select_strobe_n_ff <= 1'b0;
              tmr_ff <= LOW_CYC - 8'h01;
              state_ff <= S_SLOW;
            end
          end
        end
        S_BLOW: begin
          // enables are level acting: held for the full low window
          if (tmr_ff == 8'h00) begin
            select_strobe_n_ff <= 1'b1;
            lower_byte_enable_n_ff <= 1'b1;
            upper_byte_enable_n_ff <= 1'b1; // R14
            tmr_ff <= LOW_CYC - 8'h01;
            state_ff <= S_BHIGH;
          end
        end
        S_BHIGH: begin
          if (tmr_ff == 8'h00) begin
            if (~upper_done_ff) begin
              upper_done_ff <= 1'b1;
              byte_bus_ff <= sh_ff[15:8];
              upper_byte_enable_n_ff <= 1'b0; // R12
              select_strobe_n_ff <= 1'b0;
              tmr_ff <= LOW_CYC - 8'h01;
              state_ff <= S_BLOW;
            end else begin
              tmr_ff <= LGAP_CYC - 8'h01;
              state_ff <= ctrl_ff[`DSB_CTRL_AUTO_LOAD] ? S_LGAP : S_IDLE;
            end
          end
        end
        S_LGAP: begin
          if (tmr_ff == 8'h00) begin
            output_latch_load_ff <= 1'b1; // R6
            tmr_ff <= LOAD_CYC - 8'h01;
            state_ff <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (tmr_ff == 8'h00) begin
            output_latch_load_ff <= 1'b0;
            state_ff <= S_IDLE;
          end
        end
        S_CSET: begin
          if (tmr_ff == 8'h00) begin
            // device clears at once; first rank data survive for a reload
            zero_output_strobe_n_ff <= 1'b0; // R7 R15
            tmr_ff <= CLR_CYC - 8'h01;
            state_ff <= S_CLR;
          end
        end
        S_CLR: begin
          if (tmr_ff == 8'h00) begin
            zero_output_strobe_n_ff <= 1'b1;
            tmr_ff <= CHOLD_CYC - 8'h01;
            state_ff <= S_CHOLD;
          end
        end
        S_CHOLD: begin
          // lower enable held past the strobe release, then idle restores it
          if (tmr_ff == 8'h00) begin
            state_ff <= S_IDLE;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: bench/dsb_host_monitor.sv
// concurrent checks on the pins and register port of the dac host
module dsb_host_monitor (
  input logic clk, // clock
  input logic rst, // async reset
  input logic ce, // clock enable
  input logic [3:0] addr, // address
  input logic [31:0] wdata, // write data
  input logic wr, // write strobe
  input logic rd, // read strobe
  input logic [31:0] rdata_ff, // read data
  input logic serial_select_n_ff, // mode pin
  input logic [7:0] byte_bus_ff, // data bus
  input logic upper_byte_enable_n_ff, // upper enable
  input logic lower_byte_enable_n_ff, // lower enable
  input logic select_strobe_n_ff, // select strobe
  input logic output_latch_load_ff, // load
  input logic zero_output_strobe_n_ff, // clear strobe
  input logic serial_data_out // chain output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // -------------------------------------------------------------
  // select strobe and data bus
  // -------------------------------------------------------------
  // the device samples on the rising edge, so the bit must not move there
  serial_bit_hold_a: assert property (
    $rose(select_strobe_n_ff) && !serial_select_n_ff |-> $stable(byte_bus_ff[1:0]))
    else $error("serial bit changed at strobe rise");
  strobe_low_width_a: assert property (
    $fell(select_strobe_n_ff) |-> ##10 $rose(select_strobe_n_ff))
    else $error("strobe low phase not ten cycles");
  byte_lane_one_a: assert property (
    serial_select_n_ff && !select_strobe_n_ff |-> upper_byte_enable_n_ff != lower_byte_enable_n_ff)
    else $error("byte strobe without exactly one enable");
  serial_upper_zero_a: assert property (
    !serial_select_n_ff && !select_strobe_n_ff |-> byte_bus_ff[7:2] == 6'h00)
    else $error("unused bus bits driven in serial mode");
  // mode flips only with the strobe at rest, else a stray edge shifts
  mode_change_a: assert property (
    $changed(serial_select_n_ff) |-> select_strobe_n_ff && $past(select_strobe_n_ff))
    else $error("mode pin changed around strobe");
  // -------------------------------------------------------------
  // clear, load and read data
  // -------------------------------------------------------------
  clear_setup_a: assert property (
    $fell(zero_output_strobe_n_ff) |-> $past(lower_byte_enable_n_ff, 20) == lower_byte_enable_n_ff)
    else $error("clear target not set up in time");
  clear_quiet_a: assert property (
    !zero_output_strobe_n_ff |-> $stable(lower_byte_enable_n_ff) && select_strobe_n_ff)
    else $error("lower enable or strobe moved during clear");
  clear_width_a: assert property (
    $fell(zero_output_strobe_n_ff) |-> ##22 $rose(zero_output_strobe_n_ff))
    else $error("clear pulse not twenty-two cycles");
  load_width_a: assert property (
    $rose(output_latch_load_ff) |-> ##10 $fell(output_latch_load_ff))
    else $error("load pulse not ten cycles");
  read_idle_a: assert property (
    !$past(rd) |-> rdata_ff == 32'h0)
    else $error("read data nonzero without read");
endmodule

// file: bench/dsb_dac_model.sv
// behavioural model of the serial/byte dac digital input latches
module dsb_dac_model (
  input logic serial_select_n, // mode, low serial
  input logic [7:0] byte_bus, // data bus
  input logic upper_byte_enable_n, // upper enable
  input logic lower_byte_enable_n, // lower enable, clear target
  input logic select_strobe_n, // select strobe
  input logic output_latch_load, // dac latch load
  input logic zero_output_strobe_n, // clear strobe
  output logic serial_data_out // final shift stage
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rank_ff; // first rank latch
  logic [15:0] dac_ff; // dac latch
  // serial shift on the strobe rise; upper enable plays no part here
  always @(posedge select_strobe_n) begin
    if (!serial_select_n) begin
      if (byte_bus[1]) begin
        rank_ff = {rank_ff[14:0], byte_bus[0]};
      end else begin
        rank_ff = {byte_bus[0], rank_ff[15:1]};
      end
    end
  end
  // the stage about to leave in the current order
  assign serial_data_out = byte_bus[1] ? rank_ff[15] : rank_ff[0];
  // byte halves are transparent while enable and strobe are low
  always @* begin
    if (serial_select_n && !select_strobe_n && !lower_byte_enable_n) begin
      rank_ff[7:0] = byte_bus;
    end
    if (serial_select_n && !select_strobe_n && !upper_byte_enable_n) begin
      rank_ff[15:8] = byte_bus;
    end
  end
  // clear is async and wins; it never touches the first rank
  always @* begin
    if (!zero_output_strobe_n) begin
      dac_ff = lower_byte_enable_n ? 16'h8000 : 16'h0000;
    end else if (output_latch_load) begin
      dac_ff = rank_ff;
    end
  end
endmodule

// file: bench/dsb_host_tb.sv
// self-checking bench for the dac serial/byte host controller
`include "dsb_consts.vh"
module dsb_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_ff;
  logic [7:0] byte_bus;
  logic serial_select_n, upper_n, lower_n, strobe_n, load, clear_n, sdo;
  int err_count = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  dsb_host DUT (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .serial_select_n_ff(serial_select_n), .byte_bus_ff(byte_bus),
    .upper_byte_enable_n_ff(upper_n), .lower_byte_enable_n_ff(lower_n),
    .select_strobe_n_ff(strobe_n), .output_latch_load_ff(load),
    .zero_output_strobe_n_ff(clear_n), .serial_data_out(sdo));
  dsb_dac_model dev (.serial_select_n(serial_select_n), .byte_bus(byte_bus),
    .upper_byte_enable_n(upper_n), .lower_byte_enable_n(lower_n), .select_strobe_n(strobe_n),
    .output_latch_load(load), .zero_output_strobe_n(clear_n), .serial_data_out(sdo));
  // -------------------------------------------------------------
  // comparison, verdict and register port tasks
  // -------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata_ff;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    reg_rd(a, v);
    check(what, v, exp);
  endtask
  // polls status; a hang counts as a mismatch and ends the run
  task automatic wait_idle();
    logic [31:0] v;
    for (int i = 0; i < 20000; i++) begin
      reg_rd(`DSB_REG_STAT, v);
      if (v[0] === 1'b0 && v[1] === 1'b1 && v[5:4] === 2'b00) begin
        return;
      end
    end
    err_count++;
    results();
  endtask
  // one order to the controller, then the dac latch as the device holds it
  task automatic act(input logic [3:0] a, input logic [31:0] d, input logic [15:0] exp);
    reg_wr(a, d);
    wait_idle();
    check("dac latch", {16'h0, dev.dac_ff}, {16'h0, exp});
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check("mode pin", {31'h0, serial_select_n}, 32'h0);
    rd_chk("ctrl reset", `DSB_REG_CTRL, 32'hA);
    rd_chk("stat reset", `DSB_REG_STAT, 32'h2);
    rd_chk("cmd read", `DSB_REG_CMD, 32'h0);
    rd_chk("unmapped", 4'h2, 32'h0);
    act(`DSB_REG_DATA, 32'hFFFFA5C3, 16'hA5C3);
    act(`DSB_REG_DATA, 32'h1234, 16'h1234);
    rd_chk("chain word", `DSB_REG_DATA, 32'hA5C3);
    reg_wr(`DSB_REG_CTRL, 32'h8);
    act(`DSB_REG_DATA, 32'h0F01, 16'h0F01);
    act(`DSB_REG_CMD, 32'h2, 16'h0000);
    check("first rank", {16'h0, dev.rank_ff}, 32'h0F01);
    act(`DSB_REG_CMD, 32'h1, 16'h0F01);
    reg_wr(`DSB_REG_CTRL, 32'hC);
    act(`DSB_REG_CMD, 32'h2, 16'h8000);
    reg_wr(`DSB_REG_CTRL, 32'h9);
    act(`DSB_REG_DATA, 32'hBEEF, 16'hBEEF);
    reg_wr(`DSB_REG_CTRL, 32'hD);
    act(`DSB_REG_CMD, 32'h2, 16'h8000);
    reg_wr(`DSB_REG_CTRL, 32'h2);
    act(`DSB_REG_DATA, 32'h5555, 16'h8000);
    rd_chk("chain word", `DSB_REG_DATA, 32'hBEEF);
    act(`DSB_REG_CMD, 32'h1, 16'h5555);
    // byte words drain slowly enough for back-to-back writes to fill the buffer, yet fast enough to empty it quickly
    reg_wr(`DSB_REG_CTRL, 32'h9);
    for (int i = 0; i < 18; i++) begin
      reg_wr(`DSB_REG_DATA, 32'h0100 + i);
    end
    rd_chk("stat full", `DSB_REG_STAT, 32'hD);
    reg_wr(`DSB_REG_CTRL, 32'h0);
    rd_chk("ctrl busy", `DSB_REG_CTRL, 32'h9);
    reg_wr(`DSB_REG_STAT, 32'h8);
    rd_chk("ovf cleared", `DSB_REG_STAT, 32'h5);
    wait_idle();
    check("dac latch", {16'h0, dev.dac_ff}, 32'h0110);
    rd_chk("stat drained", `DSB_REG_STAT, 32'h2);
    // byte mode, unipolar: lower enable must drop from idle high before the clear
    act(`DSB_REG_CMD, 32'h2, 16'h0000);
    check("first rank", {16'h0, dev.rank_ff}, 32'h0110);
    // a write while the clock enable is low must leave the register alone
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(`DSB_REG_CTRL, 32'h0);
    ce <= 1'b1;
    rd_chk("ce freeze", `DSB_REG_CTRL, 32'h9);
    results();
  end
endmodule
bind dsb_host dsb_host_monitor u_mon (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .serial_select_n_ff(serial_select_n_ff),
  .byte_bus_ff(byte_bus_ff), .upper_byte_enable_n_ff(upper_byte_enable_n_ff),
  .lower_byte_enable_n_ff(lower_byte_enable_n_ff), .select_strobe_n_ff(select_strobe_n_ff),
  .output_latch_load_ff(output_latch_load_ff), .zero_output_strobe_n_ff(zero_output_strobe_n_ff),
  .serial_data_out(serial_data_out));
